// ### design/cmcz_pkg.sv
// Package with register layout, reset values and timing constants of the CAN control block.
package cmcz_pkg;
  localparam logic [1:0] CMCZ_ADDR_CTL0 = 2'h0;
  localparam logic [1:0] CMCZ_ADDR_CTL1 = 2'h1;
  localparam logic [1:0] CMCZ_ADDR_TIMER_LO = 2'h2;
  localparam logic [1:0] CMCZ_ADDR_TIMER_HI = 2'h3;
  localparam int CMCZ_BIT_RECEIVED_FRAME_FLAG = 7;
  localparam int CMCZ_BIT_RECEIVER_ACTIVE = 6;
  localparam int CMCZ_BIT_STOPWAIT = 5;
  localparam int CMCZ_BIT_SYNC = 4;
  localparam int CMCZ_BIT_TIMEN = 3;
  localparam int CMCZ_BIT_WAKEEN = 2;
  localparam int CMCZ_BIT_SLEEPRQ = 1;
  localparam int CMCZ_BIT_INIT_REQUEST = 0;
  localparam int CMCZ_BIT_INITACK = 0;
  localparam int CMCZ_BIT_SLEEPACK = 1;
  localparam int CMCZ_BIT_LOOPBACK = 5;
  localparam logic [7:0] CMCZ_CTL0_RESET = 8'h01;
  localparam logic [7:0] CMCZ_CTL1_RESET = 8'h00;
  // Bit time and idle-sequence figures.
  localparam int CMCZ_BIT_TIME_NS = 1000;
  localparam int CMCZ_CLK_PERIOD_NS = 4;
  localparam int CMCZ_BIT_CYCLES = CMCZ_BIT_TIME_NS / CMCZ_CLK_PERIOD_NS;
  localparam logic [3:0] CMCZ_IDLE_BITS = 4'hb;
  localparam logic [7:0] CMCZ_BUSOFF_SEQS = 8'h80;
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cmcz_bus_req_t;
  typedef struct packed {
    logic frame_ok;
    logic rx_busy;
    logic tx_busy;
    logic ack_seen;
    logic bus_off;
  } cmcz_link_stat_t;
endpackage

// ### design/cmcz_ctrl.sv
// CAN control register zero with init and sleep handshakes, time-stamp timer and bus sync.
`timescale 1ns/1ns
module cmcz_ctrl (
  input wire logic clk_sys_i, // System clock, 250 MHz.
  input wire logic srst_i, // Synchronous reset, active high.
  input wire logic [1:0] addr_i, // Register address.
  input wire logic [7:0] wdata_i, // Write data.
  input wire logic wr_i, // Write strobe.
  input wire logic rd_i, // Read strobe.
  output logic [7:0] rdata_o, // Read data, one cycle after the strobe.
  input wire logic rx_pin_i, // CAN receive pin, asynchronous.
  input wire logic tx_bit_i, // Bit the protocol engine wants to send.
  output logic transmit_pin_o, // CAN transmit pin, 1 is recessive.
  input wire cmcz_pkg::cmcz_link_stat_t link_i, // Protocol engine status.
  input wire logic wait_mode_i, // Processor in wait mode.
  input wire logic stop_mode_i, // Processor in stop mode.
  output logic module_clk_en_o, // Clock enable of the bus interface.
  output logic abort_o, // Abort any transfer, level.
  output logic stamp_we_o, // Time stamp write pulse.
  output logic [15:0] stamp_o, // Time stamp for buffer bytes 0x0e and 0x0f.
  output logic sleeping_o // Module in sleep mode.
);
  import cmcz_pkg::*;

  typedef enum logic [3:0] {
    CMCZ_RUN = 4'b0001,
    CMCZ_INIT = 4'b0010,
    CMCZ_SLEEP = 4'b0100,
    CMCZ_RESYNC = 4'b1000
  } cmcz_state_t;

  cmcz_state_t state;
  logic received_frame_flag, receiver_active, stop_wait, sync, timen, wakeen, sleeprq, init_request, loopback;
  logic rx_meta, rx_sync, rx_prev;
  logic [15:0] timer;
  logic [15:0] bit_cnt;
  logic bit_tick;
  logic [3:0] rec_cnt;
  logic [7:0] seq_cnt;
  logic busoff_at_init;
  logic init_mode, init_ack, sleep_ack;
  logic wr0, wr1;
  logic traffic;

  assign init_ack = (state == CMCZ_INIT);
  assign sleep_ack = (state == CMCZ_SLEEP);
  assign init_mode = init_request & init_ack;
  assign wr0 = wr_i && addr_i == CMCZ_ADDR_CTL0;
  assign wr1 = wr_i && addr_i == CMCZ_ADDR_CTL1;
  assign traffic = rx_prev & ~rx_sync;
  assign abort_o = init_request;
  assign sleeping_o = sleep_ack;
  // Pin is released in stop mode, gated wait or whenever init is requested.
  assign transmit_pin_o = (stop_mode_i | (wait_mode_i & stop_wait) | init_request) ? 1'b1
                          : tx_bit_i;
  assign module_clk_en_o = ~(wait_mode_i & stop_wait);

  // Receive pin synchroniser; reset to the recessive level so no false edge follows reset.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_meta <= rx_pin_i;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end

  // Bit clock enable divider.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || bit_cnt == 16'(CMCZ_BIT_CYCLES - 1)) begin
      bit_cnt <= 16'h0000;
    end else begin
      bit_cnt <= bit_cnt + 16'h0001;
    end
  end
  assign bit_tick = (bit_cnt == 16'(CMCZ_BIT_CYCLES - 1));

  // Mode sequencer: init handshake, sleep handshake, resynchronisation.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state <= CMCZ_INIT;
      busoff_at_init <= 1'b0;
    end else begin
      case (state)
        CMCZ_RUN: begin
          if (init_request) begin
            state <= CMCZ_INIT;
            busoff_at_init <= link_i.bus_off;
          end else if (sleeprq && !link_i.rx_busy && !link_i.tx_busy) begin
            state <= CMCZ_SLEEP;
          end
        end
        CMCZ_INIT: begin
          if (!init_request) begin
            state <= CMCZ_RESYNC;
          end
        end
        CMCZ_SLEEP: begin
          if (init_request) begin
            state <= CMCZ_INIT;
            busoff_at_init <= link_i.bus_off;
          end else if (!sleeprq) begin
            state <= CMCZ_RUN;
          end
        end
        CMCZ_RESYNC: begin
          if (init_request) begin
            state <= CMCZ_INIT;
            busoff_at_init <= link_i.bus_off;
          end else if (sync) begin
            state <= CMCZ_RUN;
          end
        end
        default: state <= CMCZ_INIT;
      endcase
    end
  end

  // Idle sequence counting for resynchronisation.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || init_request) begin
      rec_cnt <= 4'h0;
      seq_cnt <= 8'h00;
      sync <= 1'b0;
    end else if (state == CMCZ_RESYNC && !sync && bit_tick) begin
      if (!rx_sync) begin
        rec_cnt <= 4'h0;
      end else if (rec_cnt == CMCZ_IDLE_BITS - 4'h1) begin
        rec_cnt <= 4'h0;
        if (!busoff_at_init || seq_cnt == CMCZ_BUSOFF_SEQS - 8'h01) begin
          sync <= 1'b1;
        end else begin
          seq_cnt <= seq_cnt + 8'h01;
        end
      end else begin
        rec_cnt <= rec_cnt + 4'h1;
      end
    end else if (link_i.bus_off) begin
      sync <= 1'b0;
    end
  end

  // Init request bit, set by a write at any time, cleared by a write only while init is acknowledged.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      init_request <= CMCZ_CTL0_RESET[CMCZ_BIT_INIT_REQUEST];
    end else if (wr0) begin
      if (wdata_i[CMCZ_BIT_INIT_REQUEST] || init_ack) begin
        init_request <= wdata_i[CMCZ_BIT_INIT_REQUEST];
      end
    end
  end

  // Sleep request and wakeup enable, kept through init mode.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      sleeprq <= CMCZ_CTL0_RESET[CMCZ_BIT_SLEEPRQ];
      wakeen <= CMCZ_CTL0_RESET[CMCZ_BIT_WAKEEN];
    end else begin
      if (wr0 && !init_mode && !init_request) begin
        wakeen <= wdata_i[CMCZ_BIT_WAKEEN];
        if (wdata_i[CMCZ_BIT_SLEEPRQ] || !sleeprq || sleep_ack) begin
          sleeprq <= wdata_i[CMCZ_BIT_SLEEPRQ];
        end
      end
      if (sleep_ack && wakeen && traffic) begin
        sleeprq <= 1'b0;
      end
    end
  end

  // Control bits held at reset values during init mode.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || init_mode) begin
      stop_wait <= CMCZ_CTL0_RESET[CMCZ_BIT_STOPWAIT];
      timen <= CMCZ_CTL0_RESET[CMCZ_BIT_TIMEN];
    end else if (wr0 && !init_request) begin
      stop_wait <= wdata_i[CMCZ_BIT_STOPWAIT];
      timen <= wdata_i[CMCZ_BIT_TIMEN];
    end
  end

  // Received frame flag: set wins over a clearing write.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || init_mode) begin
      received_frame_flag <= CMCZ_CTL0_RESET[CMCZ_BIT_RECEIVED_FRAME_FLAG];
    end else if (link_i.frame_ok && !loopback) begin
      received_frame_flag <= 1'b1;
    end else if (wr0 && !init_request && wdata_i[CMCZ_BIT_RECEIVED_FRAME_FLAG]) begin
      received_frame_flag <= 1'b0;
    end
  end

  // Receiver active status, never written by software.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || init_mode) begin
      receiver_active <= CMCZ_CTL0_RESET[CMCZ_BIT_RECEIVER_ACTIVE];
    end else begin
      receiver_active <= link_i.rx_busy & ~loopback;
    end
  end

  // Loopback selection, read in control register one.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      loopback <= CMCZ_CTL1_RESET[CMCZ_BIT_LOOPBACK];
    end else if (wr1 && init_mode) begin
      loopback <= wdata_i[CMCZ_BIT_LOOPBACK];
    end
  end

  // Free-running time-stamp timer at the bit rate.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !timen) begin
      timer <= 16'h0000;
    end else if (bit_tick) begin
      timer <= timer + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      stamp_we_o <= 1'b0;
      stamp_o <= 16'h0000;
    end else begin
      stamp_we_o <= timen & link_i.ack_seen;
      if (timen && link_i.ack_seen) begin
        stamp_o <= timer;
      end
    end
  end

  // Register read port, data stand one cycle after the strobe.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !rd_i) begin
      rdata_o <= 8'h00;
    end else if (addr_i == CMCZ_ADDR_CTL0) begin
      rdata_o <= {received_frame_flag, receiver_active, stop_wait, sync, timen, wakeen, sleeprq, init_request};
    end else if (addr_i == CMCZ_ADDR_CTL1) begin
      rdata_o <= {2'b00, loopback, 3'b000, sleep_ack, init_ack};
    end else if (addr_i == CMCZ_ADDR_TIMER_LO) begin
      rdata_o <= timer[7:0];
    end else begin
      rdata_o <= timer[15:8];
    end
  end
endmodule

// ### sim/cmcz_can_far.sv
// Far-side model: CAN receive pin and protocol engine status seen by the block.
`timescale 1ns/1ns
module cmcz_can_far (
  input wire logic clk_i, // System clock.
  output logic rx_pin_o, // Receive pin, recessive while the bus is idle.
  output cmcz_pkg::cmcz_link_stat_t link_o // Protocol engine status.
);
  import cmcz_pkg::*;
  initial begin
    rx_pin_o = 1'b1;
    link_o = '0;
  end
  task automatic frame();
    @(posedge clk_i);
    link_o.frame_ok <= 1'b1;
    @(posedge clk_i);
    link_o.frame_ok <= 1'b0;
  endtask
  task automatic ack();
    @(posedge clk_i);
    link_o.ack_seen <= 1'b1;
    @(posedge clk_i);
    link_o.ack_seen <= 1'b0;
  endtask
  task automatic wake();
    @(posedge clk_i);
    rx_pin_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    rx_pin_o <= 1'b1;
  endtask
  task automatic busy(input logic v);
    @(posedge clk_i);
    link_o.rx_busy <= v;
  endtask
endmodule

// ### sim/cmcz_ctrl_chk.sv
// Assertion checker for the control register zero block.
`timescale 1ns/1ns
module cmcz_ctrl_chk (
  input wire logic clk_sys_i, // System clock.
  input wire logic srst_i, // Synchronous reset.
  input wire logic rd_i, // Read strobe.
  input wire logic [7:0] rdata_o, // Read data.
  input wire logic tx_bit_i, // Engine bit.
  input wire logic transmit_pin_o, // Transmit pin.
  input wire cmcz_pkg::cmcz_link_stat_t link_i, // Engine status.
  input wire logic wait_mode_i, // Wait mode.
  input wire logic stop_mode_i, // Stop mode.
  input wire logic module_clk_en_o, // Interface clock enable.
  input wire logic abort_o, // Abort level.
  input wire logic stamp_we_o, // Stamp pulse.
  input wire logic [15:0] stamp_o // Stamp value.
);
  import cmcz_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  a_read_zero_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside its slot");
  a_stop_recessive: assert property (stop_mode_i |-> transmit_pin_o)
    else $error("pin not recessive in stop");
  a_gate_wait_only: assert property (!module_clk_en_o |-> wait_mode_i && transmit_pin_o)
    else $error("clock gated outside wait");
  a_abort_recessive: assert property (abort_o |-> transmit_pin_o)
    else $error("pin not recessive in init");
  a_tx_follows_bit: assert property (!stop_mode_i && !wait_mode_i && !abort_o |->
    transmit_pin_o == tx_bit_i)
    else $error("pin does not follow engine bit");
  a_stamp_on_ack: assert property (stamp_we_o |-> $past(link_i.ack_seen))
    else $error("stamp without acknowledge");
  a_init_after_reset: assert property ($past(srst_i) |-> abort_o)
    else $error("init request not set by reset");
  a_stamp_hold: assert property ($changed(stamp_o) |-> stamp_we_o)
    else $error("stamp changed without pulse");
endmodule
bind cmcz_ctrl cmcz_ctrl_chk i_cmcz_ctrl_chk (.clk_sys_i, .srst_i, .rd_i, .rdata_o, .tx_bit_i,
  .transmit_pin_o, .link_i, .wait_mode_i, .stop_mode_i, .module_clk_en_o, .abort_o, .stamp_we_o,
  .stamp_o);

// ### sim/tb_can_module_control_zero.sv
// Self-checking testbench of the control register zero block.
`timescale 1ns/1ns
module tb_can_module_control_zero;
  import cmcz_pkg::*;
  logic clk_sys_i = 0, srst_i = 1, wr_i = 0, rd_i = 0, tx_bit_i = 1;
  logic wait_mode_i = 0, stop_mode_i = 0, rx_pin;
  logic [1:0] addr_i = 2'h0;
  logic [7:0] wdata_i = 8'h00, rdata_o;
  logic transmit_pin_o, module_clk_en_o, abort_o, stamp_we_o, sleeping_o;
  logic [15:0] stamp_o;
  cmcz_link_stat_t link;
  int err_count = 0, total_checks = 0, m = 0, cfg = 0;
  integer seed = 32'hcdee076f;
  always #2 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) tx_bit_i <= 1'($random(seed));
  cmcz_ctrl i_cmcz_ctrl (.clk_sys_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .rx_pin_i(rx_pin), .tx_bit_i, .transmit_pin_o, .link_i(link), .wait_mode_i, .stop_mode_i,
    .module_clk_en_o, .abort_o, .stamp_we_o, .stamp_o, .sleeping_o);
  cmcz_can_far i_cmcz_can_far (.clk_i(clk_sys_i), .rx_pin_o(rx_pin), .link_o(link));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 chk("rdata", {8'h00, e}, {8'h00, rdata_o});
  endtask
  task automatic end_sim();
    if (err_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    m = 8'h01;
    rd(CMCZ_ADDR_CTL0, m[7:0]);
    rd(CMCZ_ADDR_CTL1, 8'h01);
    wr(CMCZ_ADDR_CTL0, 8'h2d);
    rd(CMCZ_ADDR_CTL0, m[7:0]);
    wr(CMCZ_ADDR_CTL0, 8'h00);
    repeat (8) @(posedge clk_sys_i);
    rd(CMCZ_ADDR_CTL1, 8'h00);
    repeat (2680) @(posedge clk_sys_i);
    rd(CMCZ_ADDR_CTL0, 8'h00);
    repeat (100) @(posedge clk_sys_i);
    rd(CMCZ_ADDR_CTL0, 8'h10);
    repeat (4) begin
      cfg = $random(seed);
      wr(CMCZ_ADDR_CTL0, cfg[7:0] & 8'h6c);
      m = (cfg & 32'h2c) | 32'h10;
      rd(CMCZ_ADDR_CTL0, m[7:0]);
    end
    m = 8'h1c;
    wr(CMCZ_ADDR_CTL0, 8'h14);
    rd(CMCZ_ADDR_TIMER_LO, 8'h00);
    wr(CMCZ_ADDR_CTL0, m[7:0]);
    repeat (5 * CMCZ_BIT_CYCLES) @(posedge clk_sys_i);
    i_cmcz_can_far.ack();
    #1 chk("stamp_we", 16'h1, {15'h0, stamp_we_o});
    chk("stamp", 16'h1, {15'h0, stamp_o inside {[16'h4:16'h6]}});
    i_cmcz_can_far.frame();
    rd(CMCZ_ADDR_CTL0, m[7:0] | 8'h80);
    wr(CMCZ_ADDR_CTL0, m[7:0]);
    rd(CMCZ_ADDR_CTL0, m[7:0] | 8'h80);
    wr(CMCZ_ADDR_CTL0, m[7:0] | 8'h80);
    rd(CMCZ_ADDR_CTL0, m[7:0]);
    i_cmcz_can_far.busy(1'b1);
    rd(CMCZ_ADDR_CTL0, m[7:0] | 8'h40);
    i_cmcz_can_far.busy(1'b0);
    @(posedge clk_sys_i);
    wait_mode_i <= 1'b1;
    @(posedge clk_sys_i);
    #1 chk("clk_en", 16'h1, {15'h0, module_clk_en_o});
    wr(CMCZ_ADDR_CTL0, 8'h3c);
    #1 chk("clk_gated", 16'h0, {15'h0, module_clk_en_o});
    @(posedge clk_sys_i);
    wait_mode_i <= 1'b0;
    stop_mode_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    stop_mode_i <= 1'b0;
    wr(CMCZ_ADDR_CTL0, 8'h3e);
    rd(CMCZ_ADDR_CTL1, 8'h02);
    chk("sleeping", 16'h1, {15'h0, sleeping_o});
    i_cmcz_can_far.wake();
    #1 chk("awake", 16'h0, {15'h0, sleeping_o});
    rd(CMCZ_ADDR_CTL0, 8'h3c);
    wr(CMCZ_ADDR_CTL0, 8'h3d);
    #1 chk("abort", 16'h1, {15'h0, abort_o});
    repeat (20) @(posedge clk_sys_i);
    rd(CMCZ_ADDR_CTL0, 8'h05);
    end_sim();
  end
endmodule
